// File: hw/ana_pkg.sv
/*
  Constants for the auto-negotiation ability register bank.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package ana_pkg;
  // ----------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------
  localparam logic [5:0] IDX_ADV = 6'h04;
  localparam logic [5:0] IDX_LP = 6'h05;
  localparam logic [5:0] IDX_EXP = 6'h06;
  localparam logic [5:0] IDX_IRQ_ST = 6'h08;
  localparam logic [5:0] IDX_IRQ_MSK = 6'h09;
  localparam logic [5:0] IDX_PAUSE = 6'h0a;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_NP = 15;
  localparam int B_ACK = 14;
  localparam int B_RF = 13;
  localparam int B_ASYM = 11;
  localparam int B_PAUSE = 10;
  localparam int B_T4 = 9;
  localparam int B_TXFD = 8;
  localparam int B_TX = 7;
  localparam int B_10FD = 6;
  localparam int B_10 = 5;
  localparam int B_PDF = 4;
  localparam int B_LPNP = 3;
  localparam int B_NPA = 2;
  localparam int B_PGR = 1;
  localparam int B_LPAN = 0;
  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [4:0] SEL_8023 = 5'h01;
  localparam logic [15:0] ADV_RST = 16'h0081;
  localparam logic [15:0] ADV_WMASK = 16'h2dff;
  localparam logic [15:0] LP_RST = 16'h0001;
  localparam logic [15:0] LP_MASK = 16'he7ff;
  localparam logic [15:0] STRAP_MASK = 16'h0160;
  // Pause resolution codes
  localparam logic [1:0] PAUSE_NONE = 2'h0;
  localparam logic [1:0] PAUSE_SYM = 2'h1;
  localparam logic [1:0] PAUSE_ASYM = 2'h2;
  // Interrupt status bits
  localparam int IRQ_N = 3;
  localparam int I_PGR = 0;
  localparam int I_PDF = 1;
  localparam int I_ANC = 2;
  // Cycles to settle the strap synchroniser before loading
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage

// File: hw/ana_regs.sv
/*
  Auto-negotiation ability register bank: local advertisement, partner
  ability image, expansion status, plus interrupt status/mask and the
  resolved pause setting, all on a classic Wishbone slave.
  Assumes the arbitration logic shares mclk; only the strap pins are
  asynchronous and pass a two-flop synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Two-bit pause advertisement field, writable, resets to zero.
// - With both pause bits set, resolve to at most one setting.
// - Writable local remote-fault bit 13, resets to zero.
// - Technology bits writable except T4 (bit 9, zero); 100 Mbps resets one, others from straps.
// - Selector resets to 00001; writable locally, read-only for partner.
// - Read-only partner register at index 5, zero except selector.
// - Partner pause bit shows whether partner advertises pause.
// - Partner acknowledge bit becomes one once a code word arrives.
// - Partner next-page bit shows the received next-page claim.
// - Own next-page-able bit always reads zero.
// - Partner T4 bit reported though T4 is unsupported.
// - Parallel detection fault latches high in bit 4.
// - Page received latches high in bit 1.
// - Expansion bit 3 shows partner next page ability.
// - Expansion bit 0 shows partner auto-negotiation ability.
module ana_regs #(
  parameter int ADR_W = 8
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Mode straps (asynchronous pins)
  input wire logic strap_txfd,
  input wire logic strap_10fd,
  input wire logic strap_10,
  // Arbitration logic
  input wire logic page_rx,
  input wire logic [15:0] page_word,
  input wire logic pd_fault,
  input wire logic lp_an_able,
  input wire logic an_complete,
  output logic [15:0] adv_word,
  output logic [1:0] pause_res,
  // Interrupt
  output logic irq
);
  import ana_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] adv;
    logic [15:0] lp;
    logic pdf;
    logic pgr;
    logic [IRQ_N-1:0] ist;
    logic [IRQ_N-1:0] imsk;
    logic [1:0] pause;
    logic anc_q;
    logic [1:0] strap_cnt;
    logic [2:0] s1;
    logic [2:0] s2;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } ana_st_t;

  localparam ana_st_t ST_RST = '{
    adv: ADV_RST,
    lp: LP_RST,
    pdf: 1'b0,
    pgr: 1'b0,
    ist: '0,
    imsk: '0,
    pause: PAUSE_NONE,
    anc_q: 1'b0,
    strap_cnt: 2'h0,
    s1: 3'h0,
    s2: 3'h0,
    ack: 1'b0,
    dat: 32'h0,
    irq: 1'b0
  };

  // Counter parks one past the load point so the straps load exactly once
  localparam logic [1:0] STRAP_DONE = STRAP_SETTLE + 2'h1;

  ana_st_t st;
  ana_st_t next_st;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  // Expansion word: latched flags plus live partner status
  function automatic logic [15:0] exp_word(input ana_st_t s, input logic lpan);
    logic [15:0] w;
    w = 16'h0;
    w[B_PDF] = s.pdf;
    w[B_LPNP] = s.lp[B_NP];
    w[B_NPA] = 1'b0;
    w[B_PGR] = s.pgr;
    w[B_LPAN] = lpan;
    return w;
  endfunction

  // Unmapped indices read as zero
  function automatic logic [15:0] rd_word(input ana_st_t s, input logic [5:0] idx,
                                          input logic lpan);
    logic [15:0] w;
    w = 16'h0;
    case (idx)
      IDX_ADV: begin
        w = s.adv;
      end
      IDX_LP: begin
        w = s.lp;
      end
      IDX_EXP: begin
        w = exp_word(s, lpan);
      end
      IDX_IRQ_ST: begin
        w[IRQ_N-1:0] = s.ist;
      end
      IDX_IRQ_MSK: begin
        w[IRQ_N-1:0] = s.imsk;
      end
      IDX_PAUSE: begin
        w[1:0] = s.pause;
      end
      default: begin
        w = 16'h0;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // Bus helpers
  // ----------------------------------------
  // Word select from the byte address index
  function automatic logic hit(input logic [5:0] at, input logic [5:0] target);
    return at == target;
  endfunction

  // Byte lanes to a bit mask; the registers live in the low two lanes
  function automatic logic [15:0] lane_mask(input logic [3:0] sel);
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}};
    return m;
  endfunction

  // Only bits set in keep take the new data
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                          input logic [15:0] keep);
    logic [15:0] m;
    m = (old & ~keep) | (data & keep);
    return m;
  endfunction

  // Write one to clear
  function automatic logic [IRQ_N-1:0] w1c(input logic [IRQ_N-1:0] old,
                                           input logic [IRQ_N-1:0] data);
    return old & ~data;
  endfunction

  // Level request while any unmasked status bit is set
  function automatic logic irq_level(input logic [IRQ_N-1:0] stat,
                                     input logic [IRQ_N-1:0] msk);
    return |(stat & msk);
  endfunction

  // Interrupt events in status bit order
  function automatic logic [IRQ_N-1:0] ev_vec(input logic pgr, input logic pdf,
                                              input logic anc);
    logic [IRQ_N-1:0] v;
    v = '0;
    v[I_PGR] = pgr;
    v[I_PDF] = pdf;
    v[I_ANC] = anc;
    return v;
  endfunction

  // ----------------------------------------
  // Advertisement and partner helpers
  // ----------------------------------------
  // Strap values land in the three strap-defaulted ability bits
  function automatic logic [15:0] strap_apply(input logic [15:0] adv, input logic [2:0] pins);
    logic [15:0] m;
    m = adv;
    m[B_TXFD] = pins[2];
    m[B_10FD] = pins[1];
    m[B_10] = pins[0];
    return m;
  endfunction

  // Reserved 12:11 forced to zero; acknowledge set on any received word
  function automatic logic [15:0] partner_image(input logic [15:0] word);
    logic [15:0] m;
    m = word & LP_MASK;
    m[B_ACK] = 1'b1;
    return m;
  endfunction

  // Symmetric when both ends offer it, else asymmetric if asked for; a
  // single code comes out even with both advert bits set
  function automatic logic [1:0] pause_pick(input logic [15:0] adv,
                                            input logic [15:0] partner);
    logic [1:0] p;
    p = PAUSE_NONE;
    if (adv[B_PAUSE] && partner[B_PAUSE]) begin
      p = PAUSE_SYM;
    end else if (adv[B_ASYM]) begin
      p = PAUSE_ASYM;
    end
    return p;
  endfunction

  // ----------------------------------------
  // Next-state signals
  // ----------------------------------------
  // Bus decode
  logic req;
  logic wr;
  logic rd_exp;
  logic [5:0] idx;
  logic [15:0] wmask;
  // Write strobes per register
  logic wr_adv;
  logic wr_imsk;
  logic wr_ist;
  // Events and strap timing
  logic [IRQ_N-1:0] ev;
  logic anc_rise;
  logic strap_load;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Events and bus writes are both applied in one pass; where they meet
  // on the same bit, the event is applied last so it is never lost.
  always_comb begin
    next_st = st;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Taken only while ack is low, so a held stb is not taken twice
    idx = wb_adr_i[7:2];
    req = wb_cyc_i & wb_stb_i & ~st.ack;
    wr = req & wb_we_i;
    rd_exp = req & ~wb_we_i & hit(idx, IDX_EXP);
    wmask = lane_mask(wb_sel_i);
    wr_adv = wr & hit(idx, IDX_ADV);
    wr_imsk = wr & hit(idx, IDX_IRQ_MSK) & wb_sel_i[0];
    wr_ist = wr & hit(idx, IDX_IRQ_ST) & wb_sel_i[0];

    // ----------------------------------------
    // Events
    // ----------------------------------------
    anc_rise = an_complete & ~st.anc_q;
    ev = ev_vec(page_rx, pd_fault, anc_rise);

    // ----------------------------------------
    // Straps
    // ----------------------------------------
    // Only the second flop feeds the advertisement
    next_st.s1 = {strap_txfd, strap_10fd, strap_10};
    next_st.s2 = st.s1;
    strap_load = (st.strap_cnt == STRAP_SETTLE);
    if (st.strap_cnt != STRAP_DONE) begin
      next_st.strap_cnt = st.strap_cnt + 2'h1;
    end
    if (strap_load) begin
      next_st.adv = strap_apply(st.adv, st.s2);
    end

    // ----------------------------------------
    // Bus answer and writes
    // ----------------------------------------
    // Data is registered with ack; ack stands one cycle, data holds until the next request
    next_st.ack = req;
    if (req) begin
      next_st.dat = {16'h0, rd_word(st, idx, lp_an_able)};
    end
    // A write in the strap load cycle wins over the straps
    if (wr_adv) begin
      next_st.adv = merge16(st.adv, wb_dat_i[15:0], ADV_WMASK & wmask);
    end
    if (wr_imsk) begin
      next_st.imsk = wb_dat_i[IRQ_N-1:0];
    end

    // ----------------------------------------
    // Partner image
    // ----------------------------------------
    if (page_rx) begin
      next_st.lp = partner_image(page_word);
    end

    // ----------------------------------------
    // Latched-high flags
    // ----------------------------------------
    // A read clears, a live event wins
    if (rd_exp) begin
      next_st.pdf = 1'b0;
      next_st.pgr = 1'b0;
    end
    if (pd_fault) begin
      next_st.pdf = 1'b1;
    end
    if (page_rx) begin
      next_st.pgr = 1'b1;
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    // Write one clears, set wins over clear
    if (wr_ist) begin
      next_st.ist = w1c(st.ist, wb_dat_i[IRQ_N-1:0]);
    end
    next_st.ist = next_st.ist | ev;
    next_st.irq = irq_level(next_st.ist, next_st.imsk);

    // ----------------------------------------
    // Pause resolution
    // ----------------------------------------
    // Resolved once per completion, then held until the next one
    next_st.anc_q = an_complete;
    if (anc_rise) begin
      next_st.pause = pause_pick(st.adv, st.lp);
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign adv_word = st.adv;
  assign pause_res = st.pause;
  assign irq = st.irq;
endmodule
`default_nettype wire

// File: sim/ana_regs_chk.sv
/*
  Assertion checker for the ability register bank.
  Assumes a byte-addressed Wishbone bus; ce may be dropped by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ana_regs_chk #(
  parameter int ADR_W = 8
) (
  // Watched ports
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic an_complete,
  input wire logic [15:0] adv_word,
  input wire logic [1:0] pause_res
);
  import ana_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire logic req = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
  a_ack_next: assert property (req |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack held");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper data not zero");
  a_adv_write: assert property (req && wb_we_i && wb_adr_i == 8'h10 && wb_sel_i == 4'hf
    |=> adv_word == ($past(wb_dat_i[15:0]) & ADV_WMASK)) else $error("adv write wrong");
  a_adv_reserved: assert property (adv_word[15:14] == 2'h0 && !adv_word[12] && !adv_word[9])
    else $error("adv reserved bit set");
  a_adv_reset: assert property ($rose(arst_n) |-> adv_word == ADV_RST)
    else $error("adv reset value wrong");
  a_pause_single: assert property (pause_res != 2'h3) else $error("both pause set");
  a_pause_hold: assert property (!$rose(an_complete) |=> $stable(pause_res))
    else $error("pause changed without completion");
  a_pause_none: assert property (ce && $rose(an_complete) && adv_word[11:10] == PAUSE_NONE
    |=> pause_res == PAUSE_NONE) else $error("pause without advert");
endmodule
bind ana_regs ana_regs_chk #(.ADR_W(ADR_W)) ana_regs_chk_i (.mclk, .arst_n, .ce, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .an_complete,
  .adv_word, .pause_res);
`default_nettype wire

// File: sim/ana_partner.sv
/*
  Model of the arbitration side: delivers partner code words and events.
  Assumes the caller waits for each task to return before the next one.
*/
`timescale 1ns/1ps
`default_nettype none
module ana_partner (
  // Clock
  input wire logic mclk,
  // Arbitration side
  output logic page_rx,
  output logic [15:0] page_word,
  output logic pd_fault,
  output logic lp_an_able,
  output logic an_complete
);
  // ----------------------------------------
  // Event tasks
  // ----------------------------------------
  initial begin
    {page_rx, pd_fault, lp_an_able, an_complete} = 4'h0;
    page_word = 16'h0000;
  end
  // Word is inverted after the strobe so stale data is never mistaken for valid
  task automatic page(input logic [15:0] w);
    @(posedge mclk);
    page_rx <= 1'b1;
    page_word <= w;
    @(posedge mclk);
    page_rx <= 1'b0;
    page_word <= ~w;
  endtask
  task automatic fault;
    @(posedge mclk);
    pd_fault <= 1'b1;
    lp_an_able <= 1'b1;
    @(posedge mclk);
    pd_fault <= 1'b0;
  endtask
  task automatic done;
    @(posedge mclk);
    an_complete <= 1'b0;
    @(posedge mclk);
    an_complete <= 1'b1;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// File: sim/ana_regs_tb_top.sv
/*
  Self-checking bench for the ability register bank.
  Assumes straps tied to 1,0,1; ce and byte lanes driven by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ana_regs_tb_top;
  import ana_pkg::*;
  logic mclk, arst_n, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [3:0] wb_sel_i;
  logic page_rx, pd_fault, lp_an_able, an_complete;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] page_word, adv_word;
  logic [1:0] pause_res;
  int err_total, n_compared, cyc_cnt;
  logic [7:0] ra [7] = '{8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c};
  logic [15:0] re [7] = '{ADV_RST | 16'h0120, LP_RST, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  ana_regs ana_regs_i (.mclk, .arst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .strap_txfd(1'b1), .strap_10fd(1'b0),
    .strap_10(1'b1), .page_rx, .page_word, .pd_fault, .lp_an_able, .an_complete, .adv_word,
    .pause_res, .irq);
  ana_partner ana_partner_i (.mclk, .page_rx, .page_word, .pd_fault, .lp_an_able, .an_complete);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 2000) begin
      err_total++;
      give_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Request held until ack is sampled; no fixed latency assumed
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20) err_total++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, {16'h0000, e}, q);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {arst_n, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    ce = 1'b1;
    wb_sel_i = 4'hf;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 7; i++) rd(ra[i], re[i], "reset row");
    $display("test reset values done");
    bus(1'b1, 8'h10, 32'hffffffff);
    @(negedge mclk);
    chk("adv", {16'h0000, ADV_WMASK}, {16'h0000, adv_word});
    rd(8'h18, 16'h0000, "exp npa");
    bus(1'b1, 8'h24, 32'h1);
    ana_partner_i.page(16'hbfff);
    repeat (2) @(negedge mclk);
    chk("irq page", 32'h1, {31'h0, irq});
    rd(8'h14, 16'he7ff, "lp");
    rd(8'h18, 16'h000a, "exp page");
    rd(8'h18, 16'h0008, "exp cleared");
    bus(1'b1, 8'h20, 32'h1);
    ana_partner_i.fault();
    repeat (2) @(negedge mclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(8'h18, 16'h0019, "exp fault");
    rd(8'h18, 16'h0009, "exp fault clr");
    $display("test status done");
    ana_partner_i.done();
    repeat (2) @(negedge mclk);
    chk("pause sym", {30'h0, PAUSE_SYM}, {30'h0, pause_res});
    bus(1'b1, 8'h10, 32'h0801);
    ana_partner_i.page(16'h0001);
    ana_partner_i.done();
    rd(8'h28, {14'h0, PAUSE_ASYM}, "pause asym");
    bus(1'b1, 8'h10, 32'h0001);
    ana_partner_i.done();
    rd(8'h28, {14'h0, PAUSE_NONE}, "pause none");
    $display("test pause done");
    // Low lane only: the high byte keeps its value
    @(posedge mclk);
    wb_sel_i <= 4'h1;
    bus(1'b1, 8'h10, 32'h0000ffff);
    @(posedge mclk);
    wb_sel_i <= 4'hf;
    rd(8'h10, 16'h00ff, "adv low lane");
    // Enable low: a received word is not taken
    @(posedge mclk);
    ce <= 1'b0;
    ana_partner_i.page(16'h0021);
    @(posedge mclk);
    ce <= 1'b1;
    rd(8'h14, 16'h4001, "lp frozen");
    $display("test lanes and enable done");
    give_verdict;
  end
endmodule
`default_nettype wire
